/* bench/bus_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  input wire logic clock,
  input wire logic go,
  output logic rx
);
  // Passive bus is low; a short active burst opens a frame
  logic [3:0] cnt_r = 4'h0;
  always_ff @(posedge clock)
    cnt_r <= go ? 4'h6 : (cnt_r != 4'h0 ? cnt_r - 4'h1 : 4'h0);
  assign rx = cnt_r != 4'h0;
endmodule // bus_partner
`default_nettype wire

/* bench/link_power_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module link_power_checker #(
  parameter int RESET_SOURCES = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [RESET_SOURCES-1:0] reset_sources,
  input wire logic cpu_wait_exec,
  input wire logic cpu_stop_exec,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic link_tx_digital_out,
  input wire logic core_reset,
  input wire logic core_clock_run,
  input wire logic cpu_clock_run,
  input wire logic wake_irq,
  input wire logic wake_nmi,
  input wire logic [7:0] nmi_vector,
  input wire logic [2:0] mode_code
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_source_reset: assert property (
    $rose(|reset_sources) |-> ##[1:4] mode_code == 3'h0)
    else $error("Reset source did not force reset mode");
  a_core_held: assert property (mode_code == 3'h0 |-> core_reset)
    else $error("Core not held in reset mode");
  a_rdata_idle: assert property (
    (!$past(rd) || $past(mode_code) == 3'h0) |-> rdata == 8'h00)
    else $error("Read data outside answer cycle");
  a_wait_entry: assert property (
    mode_code == 3'h1 && cpu_wait_exec && !cpu_stop_exec
    && !(|reset_sources) |=> mode_code inside {3'h2, 3'h3})
    else $error("Wait pulse did not enter low mode");
  a_stop_entry: assert property (
    mode_code == 3'h1 && cpu_stop_exec && !(|reset_sources)
    |=> mode_code == 3'h4 && !cpu_clock_run)
    else $error("Stop pulse did not stop both clocks");
  a_stop_clocks: assert property (
    mode_code inside {3'h3, 3'h4} |-> !core_clock_run)
    else $error("Core clock runs in stop mode");
  a_wait_silent: assert property (
    mode_code == 3'h2 && $past(mode_code) == 3'h2
    |-> !link_tx_digital_out)
    else $error("Transmit driven in wait mode");
  a_irq_from_wait: assert property (
    wake_irq |-> mode_code == 3'h1 && $past(mode_code) == 3'h2)
    else $error("Wake interrupt not from wait mode");
  a_nmi_vector: assert property (
    wake_nmi |-> nmi_vector == 8'h20 ##1 !wake_nmi)
    else $error("Wake NMI vector or pulse wrong");
  a_nmi_from_stop: assert property (
    wake_nmi |-> $past(mode_code) inside {3'h3, 3'h4})
    else $error("Wake NMI not from stop mode");
  c_irq: cover property (wake_irq);
  c_nmi: cover property (wake_nmi);
  c_stop_stop: cover property (mode_code == 3'h4);
endmodule // link_power_checker

bind j1850_link_power_mode_ctrl link_power_checker #(
  .RESET_SOURCES(RESET_SOURCES)
) chk (.clock, .reset, .reset_sources, .cpu_wait_exec, .cpu_stop_exec,
  .rd, .rdata, .link_tx_digital_out, .core_reset, .core_clock_run,
  .cpu_clock_run, .wake_irq, .wake_nmi, .nmi_vector, .mode_code);
`default_nettype wire

/* bench/tb_j1850_link_power_mode_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_j1850_link_power_mode_ctrl;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [1:0] srcs = 2'h0;
  logic wt = 1'b0;
  logic sp = 1'b0;
  logic ctx = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [7:0] code = 8'h04;
  logic rx, tx, rxc, crst, crun, prun, irq, nmi, part;
  logic [7:0] rdata, vec;
  logic [2:0] mode;
  int errors = 0;
  int compares = 0;
  always #4 clock = ~clock;
  bus_partner bus (.clock(clock), .go(go), .rx(rx));
  j1850_link_power_mode_ctrl #(.RESET_SOURCES(2), .IDLE_CYCLES(8)) dut (
    .clock(clock), .reset(reset), .reset_sources(srcs),
    .cpu_wait_exec(wt), .cpu_stop_exec(sp), .core_tx(ctx),
    .core_state_code(code), .link_rx_digital_in(rx), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .link_tx_digital_out(tx), .rx_to_core(rxc), .core_reset(crst),
    .core_clock_run(crun), .cpu_clock_run(prun), .wake_irq(irq),
    .wake_nmi(nmi), .nmi_vector(vec), .mode_code(mode),
    .net_participate(part));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic pulse(input logic w, input logic s);
    @(posedge clock);
    wt <= w;
    sp <= s;
    @(posedge clock);
    wt <= 1'b0;
    sp <= 1'b0;
    tick(1);
  endtask
  task automatic burst();
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
  endtask
  task automatic wake(input logic want_nmi);
    logic [1:0] seen;
    logic got_rx;
    seen = 2'h0;
    got_rx = 1'b0;
    burst();
    repeat (20) begin
      @(posedge clock);
      #1;
      seen = seen | {nmi, irq};
      got_rx = got_rx | rxc;
    end
    check(8'(seen), want_nmi ? 8'h02 : 8'h01);
    check(8'(mode), 8'h01);
    check({6'h00, crun, prun}, 8'h03);
    if (!want_nmi) check(8'(got_rx), 8'h01);
  endtask
  task automatic test_regs();
    logic [7:0] d;
    rreg(4'h0, d);
    check(d, 8'h00);
    rreg(4'h1, d);
    check(d, 8'h00);
    wreg(4'h0, 8'hA4);
    rreg(4'h0, d);
    check(d, 8'hA4);
    rreg(4'hF, d);
    check(d, 8'h00);
    rreg(4'h2, d);
    check(d, 8'h04);
    rreg(4'h3, d);
    check(d & 8'hE5, 8'h25);
  endtask
  task automatic test_wait();
    logic [7:0] d;
    pulse(1'b1, 1'b0);
    check(8'(mode), 8'h02);
    @(posedge clock);
    ctx <= 1'b1;
    tick(2);
    check(8'(tx), 8'h00);
    @(posedge clock);
    ctx <= 1'b0;
    wake(1'b0);
    rreg(4'h0, d);
    check(d, 8'hA4);
  endtask
  task automatic test_stop_wait();
    logic [7:0] d;
    wreg(4'h0, 8'h03);
    code <= 8'h0C;
    rreg(4'h2, d);
    check(d, 8'h0C);
    pulse(1'b1, 1'b0);
    check(8'(mode), 8'h03);
    wake(1'b1);
    rreg(4'h3, d);
    check(d & 8'h0A, 8'h0A);
    rreg(4'h2, d);
    check(d, 8'h20);
    @(posedge clock);
    code <= 8'h04;
    rreg(4'h2, d);
    check(d, 8'h04);
    pulse(1'b1, 1'b0);
    check(8'(mode), 8'h03);
    check({6'h00, crun, prun}, 8'h01);
    wake(1'b1);
    check(vec, 8'h20);
    rreg(4'h3, d);
    check(d & 8'h0A, 8'h08);
    rreg(4'h2, d);
    check(d, 8'h20);
    rreg(4'h2, d);
    check(d, 8'h04);
    rreg(4'h0, d);
    check(d, 8'h03);
  endtask
  task automatic test_stop_stop();
    logic [7:0] d;
    pulse(1'b0, 1'b1);
    check(8'(mode), 8'h04);
    check({6'h00, crun, prun}, 8'h00);
    wake(1'b1);
    rreg(4'h3, d);
    check(d & 8'h02, 8'h02);
  endtask
  task automatic test_analog();
    check(8'(part), 8'h01);
    wreg(4'h1, 8'h02);
    wreg(4'h1, 8'h00);
    tick(3);
    check(8'(part), 8'h00);
    repeat (30) if (part !== 1'b1) tick(1);
    check(8'(part), 8'h01);
  endtask
  task automatic test_loopback();
    logic [7:0] d;
    rreg(4'h2, d);
    check(d, 8'h20);
    rreg(4'h3, d);
    check(d & 8'h0A, 8'h00);
    wreg(4'h1, 8'h01);
    ctx <= 1'b1;
    tick(3);
    check({6'h00, rxc, tx}, 8'h02);
    @(posedge clock);
    ctx <= 1'b0;
    pulse(1'b1, 1'b0);
    burst();
    tick(20);
    check(8'(mode), 8'h03);
    @(posedge clock);
    srcs <= 2'h2;
    tick(5);
    check(8'(mode), 8'h00);
    check(8'(crst), 8'h01);
    @(posedge clock);
    srcs <= 2'h0;
    tick(6);
    check(8'(mode), 8'h01);
    check(8'(crst), 8'h00);
    rreg(4'h1, d);
    check(d, 8'h00);
    rreg(4'h0, d);
    check(d, 8'h00);
  endtask
  task automatic print_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    tick(2);
    test_regs();
    test_wait();
    test_stop_wait();
    test_stop_stop();
    test_analog();
    test_loopback();
    print_verdict();
  end
  // Whole run is a few hundred cycles; this leaves wide margin
  initial begin
    #40000;
    errors++;
    print_verdict();
  end
endmodule // tb_j1850_link_power_mode_ctrl
`default_nettype wire

/* common/j1850_link_params.svh */
`ifndef J1850_LINK_PARAMS_SVH
`define J1850_LINK_PARAMS_SVH

// Register offsets on the plain register port
`define ADDR_LINK_CONTROL_ONE 4'h0
`define ADDR_LINK_CONTROL_TWO 4'h1
`define ADDR_STATE_VECTOR 4'h2
`define ADDR_MODE_STATUS 4'h3

// Field positions
`define WAIT_CLOCK_SELECT_POS 0
`define FOUR_X_POS 1
`define DIGITAL_LOOPBACK_POS 0
`define ANALOG_LOOPBACK_POS 1

// Reset values
`define LINK_CONTROL_ONE_RESET 8'h00
`define LINK_CONTROL_TWO_RESET 8'h00

// State vector codes and wakeup vector
`define STATE_VECTOR_WAKE_CODE 8'h20
`define STATE_VECTOR_EOF_CODE 8'h04
`define WAKE_NMI_VECTOR 8'h20

// Timing
`define CLOCK_PERIOD_NS 8
`define BUS_IDLE_TIME_NS 300000
`define BUS_IDLE_CYCLES \
  ((`BUS_IDLE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

/* common/link_power_pkg.sv */
`default_nettype none

package link_power_pkg;

  typedef enum logic [2:0] {
    st_reset,
    st_run,
    st_wait,
    st_stop_cpu_wait,
    st_stop_cpu_stop
  } mode_t;

endpackage

`default_nettype wire

/* common/wake_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface wake_if;
  logic rx_sync;
  logic active_edge;
  logic guard_start;
  logic guard_done;
  logic bus_idle;

  modport edge_side (output rx_sync, output active_edge);
  modport idle_side (input rx_sync, input guard_start,
                     output guard_done, output bus_idle);
  modport ctrl (input rx_sync, input active_edge, input guard_done,
                input bus_idle, output guard_start);
endinterface

`default_nettype wire

/* design/bus_idle_guard.sv */
`timescale 1ns/1ps
`default_nettype none

module bus_idle_guard #(
  parameter int IDLE_CYCLES = 37500
) (
  input wire logic clock,
  input wire logic reset,
  wake_if.idle_side wk
);

  localparam int W = $clog2(IDLE_CYCLES + 1);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic armed_r;
  logic armed_nxt;
  logic done_r;
  logic reached;

  assign reached = (count_r == W'(IDLE_CYCLES - 1)) & ~wk.rx_sync;
  // Any active level restarts the idle measurement
  assign count_nxt = (wk.guard_start | wk.rx_sync | reached) ? '0 :
                     count_r + W'(1);
  assign armed_nxt = wk.guard_start | (armed_r & ~reached);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_r <= '0;
      armed_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      armed_r <= armed_nxt;
      done_r <= armed_r & reached & ~wk.guard_start;
    end
  end

  assign wk.guard_done = done_r;
  assign wk.bus_idle = ~armed_r;

endmodule // bus_idle_guard

`default_nettype wire

/* design/j1850_link_power_mode_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

`include "j1850_link_params.svh"

// Overview of operation
// - Any reset source forces reset mode
// - Reset mode clears registers, ignores inputs
// - Leave reset to run when sources deassert
// - WAIT picks low mode by select bit; STOP always full stop
// - Bus activity returns low modes to run
// - Stop wakeup raises NMI, top vector code
// - Low modes and wakeup keep registers
// - Wait mode: clocks run, no transmit
// - Wait wake: first rising edge interrupts
// - Select set plus WAIT stops core clocks
// - Stop wake: first rising edge gives NMI
// - Select set plus STOP stops both clocks
// - Stop wakeup message may be lost
// - Loopback set keeps bus from waking
// - Wakeup identical in normal and 4X
// - Digital loopback joins tx to rx internally
// - After analog loopback wait bus idle
module j1850_link_power_mode_ctrl #(
  parameter int RESET_SOURCES = 2,
  parameter int IDLE_CYCLES = `BUS_IDLE_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [RESET_SOURCES-1:0] reset_sources,
  input wire logic cpu_wait_exec,
  input wire logic cpu_stop_exec,
  input wire logic core_tx,
  input wire logic [7:0] core_state_code,
  input wire logic link_rx_digital_in,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic link_tx_digital_out,
  output logic rx_to_core,
  output logic core_reset,
  output logic core_clock_run,
  output logic cpu_clock_run,
  output logic wake_irq,
  output logic wake_nmi,
  output logic [7:0] nmi_vector,
  output logic [2:0] mode_code,
  output logic net_participate
);

  wake_if wk ();

  wake_edge_detect u_edge (
    .clock(clock),
    .reset(reset),
    .link_rx_digital_in(link_rx_digital_in),
    .wk(wk.edge_side)
  );

  // Idle guard only matters after analog loopback exit
  bus_idle_guard #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_idle (
    .clock(clock),
    .reset(reset),
    .wk(wk.idle_side)
  );

  // Reset sources come from pins or other domains
  logic [RESET_SOURCES-1:0] src_meta_r;
  logic [RESET_SOURCES-1:0] src_sync_r;
  logic src_any;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      src_meta_r <= '0;
      src_sync_r <= '0;
    end else begin
      src_meta_r <= reset_sources;
      src_sync_r <= src_meta_r;
    end
  end

  assign src_any = |src_sync_r;

  link_power_pkg::mode_t mode_r;
  link_power_pkg::mode_t mode_nxt;

  logic [7:0] ctrl_one_r;
  logic [7:0] ctrl_one_nxt;
  logic [7:0] ctrl_two_r;
  logic [7:0] ctrl_two_nxt;
  logic wake_pending_r;
  logic wake_pending_nxt;
  logic eof_read_r;
  logic eof_read_nxt;
  logic msg_lost_r;
  logic msg_lost_nxt;
  logic participate_r;
  logic participate_nxt;
  // Cleared in reset so leaving reset is no false loopback exit
  logic analog_loopback_bit_prev_r;

  logic in_reset;
  logic in_run;
  logic in_low;
  logic in_stop;
  logic in_wait;
  logic wait_select;
  logic digital_loopback_bit;
  logic analog_loopback_bit;
  logic disengaged;
  logic wake_event;
  logic stop_wake;
  logic wait_wake;
  logic wr_one;
  logic wr_two;
  logic rd_vector;
  logic [7:0] vector_code;
  logic [7:0] status_word;
  logic [7:0] read_mux;

  // Both stop flavours halt the core; decoded on mode_r and mode_nxt
  function automatic logic is_stop(input link_power_pkg::mode_t m);
    return (m == link_power_pkg::st_stop_cpu_wait) |
           (m == link_power_pkg::st_stop_cpu_stop);
  endfunction

  assign in_reset = (mode_r == link_power_pkg::st_reset);
  assign in_run = (mode_r == link_power_pkg::st_run);
  assign in_stop = is_stop(mode_r);
  assign in_wait = (mode_r == link_power_pkg::st_wait);
  assign in_low = in_stop | in_wait;

  assign wait_select = ctrl_one_r[`WAIT_CLOCK_SELECT_POS];
  assign digital_loopback_bit = ctrl_two_r[`DIGITAL_LOOPBACK_POS];
  assign analog_loopback_bit = ctrl_two_r[`ANALOG_LOOPBACK_POS];

  // Either loopback detaches the node from bus wakeups
  assign disengaged = digital_loopback_bit | analog_loopback_bit;
  // Four-times receive bit deliberately plays no part here
  assign wake_event = in_low & wk.active_edge & ~disengaged;
  assign stop_wake = wake_event & in_stop;
  assign wait_wake = wake_event & in_wait;

  // Register writes and reads are ignored while in reset
  assign wr_one = wr & ~in_reset & (addr == `ADDR_LINK_CONTROL_ONE);
  assign wr_two = wr & ~in_reset & (addr == `ADDR_LINK_CONTROL_TWO);
  assign rd_vector = rd & ~in_reset & (addr == `ADDR_STATE_VECTOR);

  // Held wakeup outranks every code from the protocol core
  assign vector_code = wake_pending_r ? `STATE_VECTOR_WAKE_CODE :
                       core_state_code;

  // Mode in the top bits for a quick software poll
  assign status_word = {mode_r, 1'b0, wake_pending_r, eof_read_r,
                        msg_lost_r, participate_r};

  // Status and state vector are read-only
  always_comb begin
    read_mux = 8'h00;
    if (!in_reset) begin
      unique case (addr)
        `ADDR_LINK_CONTROL_ONE: read_mux = ctrl_one_r;
        `ADDR_LINK_CONTROL_TWO: read_mux = ctrl_two_r;
        `ADDR_STATE_VECTOR: read_mux = vector_code;
        `ADDR_MODE_STATUS: read_mux = status_word;
        default: read_mux = 8'h00;
      endcase
    end
  end

  // Pulses outside run mode fall through with no effect
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      link_power_pkg::st_reset: begin
        if (!src_any) begin
          mode_nxt = link_power_pkg::st_run;
        end
      end
      link_power_pkg::st_run: begin
        if (cpu_stop_exec) begin
          // Stop with select clear is treated as full stop as well
          mode_nxt = link_power_pkg::st_stop_cpu_stop;
        end else if (cpu_wait_exec && wait_select) begin
          mode_nxt = link_power_pkg::st_stop_cpu_wait;
        end else if (cpu_wait_exec) begin
          mode_nxt = link_power_pkg::st_wait;
        end
      end
      link_power_pkg::st_wait,
      link_power_pkg::st_stop_cpu_wait,
      link_power_pkg::st_stop_cpu_stop: begin
        if (wake_event) begin
          mode_nxt = link_power_pkg::st_run;
        end
      end
    endcase
    // Reset sources override every other transition
    if (src_any) begin
      mode_nxt = link_power_pkg::st_reset;
    end
  end

  // Only writes and reset mode change the control registers, never a low-mode change
  assign ctrl_one_nxt = in_reset ? `LINK_CONTROL_ONE_RESET :
                        (wr_one ? wdata : ctrl_one_r);
  assign ctrl_two_nxt = in_reset ? `LINK_CONTROL_TWO_RESET :
                        (wr_two ? wdata : ctrl_two_r);

  // Set wins over the clearing read in the same cycle
  assign wake_pending_nxt = ~in_reset &
                            (stop_wake | (wake_pending_r & ~rd_vector));

  // A wakeup uses up the end-of-frame read
  assign eof_read_nxt = ~in_reset &
    ((rd_vector & (vector_code == `STATE_VECTOR_EOF_CODE)) |
     (eof_read_r & ~wake_event));

  // Stop with CPU stop loses the waking frame; stop with CPU wait
  // only keeps it when end-of-frame was seen first
  assign msg_lost_nxt = ~in_reset &
    ((stop_wake & ((mode_r == link_power_pkg::st_stop_cpu_stop) |
                   ~eof_read_r)) |
     (msg_lost_r & ~rd_vector));

  // Analog loopback exit holds the node off until bus idle
  assign wk.guard_start = analog_loopback_bit_prev_r & ~analog_loopback_bit & ~in_reset;
  // With no guard running, the node joins as soon as reset ends
  assign participate_nxt = ~in_reset &
    ((participate_r & ~wk.guard_start) | wk.guard_done |
     (~participate_r & ~analog_loopback_bit & ~analog_loopback_bit_prev_r & ~wk.guard_start &
      wk.bus_idle));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_r <= link_power_pkg::st_reset;
      ctrl_one_r <= `LINK_CONTROL_ONE_RESET;
      ctrl_two_r <= `LINK_CONTROL_TWO_RESET;
      wake_pending_r <= 1'b0;
      eof_read_r <= 1'b0;
      msg_lost_r <= 1'b0;
      participate_r <= 1'b0;
      analog_loopback_bit_prev_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      ctrl_one_r <= ctrl_one_nxt;
      ctrl_two_r <= ctrl_two_nxt;
      wake_pending_r <= wake_pending_nxt;
      eof_read_r <= eof_read_nxt;
      msg_lost_r <= msg_lost_nxt;
      participate_r <= participate_nxt;
      analog_loopback_bit_prev_r <= analog_loopback_bit & ~in_reset;
    end
  end

  // Output stage: every port leaves from a flip-flop
  logic tx_drive;
  logic rx_path;

  // Only run mode drives, and digital loopback never reaches the pin
  assign tx_drive = in_run & ~digital_loopback_bit & participate_r & core_tx;
  assign rx_path = digital_loopback_bit ? core_tx : wk.rx_sync;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
      link_tx_digital_out <= 1'b0;
      rx_to_core <= 1'b0;
      core_reset <= 1'b1;
      core_clock_run <= 1'b1;
      cpu_clock_run <= 1'b1;
      wake_irq <= 1'b0;
      wake_nmi <= 1'b0;
      nmi_vector <= 8'h00;
      mode_code <= 3'h0;
      net_participate <= 1'b0;
    end else begin
      // Read data only in the answer cycle, zero elsewhere
      rdata <= rd ? read_mux : 8'h00;
      link_tx_digital_out <= tx_drive;
      rx_to_core <= in_reset ? 1'b0 : rx_path;
      // Taken from mode_nxt so they move together with mode_code
      core_reset <= (mode_nxt == link_power_pkg::st_reset);
      core_clock_run <= ~is_stop(mode_nxt);
      cpu_clock_run <= (mode_nxt != link_power_pkg::st_stop_cpu_stop);
      wake_irq <= wait_wake;
      wake_nmi <= stop_wake;
      // Vector holds so a late interrupt entry still finds it
      nmi_vector <= stop_wake ? `WAKE_NMI_VECTOR : nmi_vector;
      mode_code <= mode_nxt;
      net_participate <= participate_nxt;
    end
  end

endmodule // j1850_link_power_mode_ctrl

`default_nettype wire

/* design/wake_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none

module wake_edge_detect (
  input wire logic clock,
  input wire logic reset,
  input wire logic link_rx_digital_in,
  wake_if.edge_side wk
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic edge_r;
  logic rising;

  // Passive is low, active is high on the bus
  assign rising = sync_r & ~prev_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      edge_r <= 1'b0;
    end else begin
      meta_r <= link_rx_digital_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      edge_r <= rising;
    end
  end

  assign wk.rx_sync = sync_r;
  assign wk.active_edge = edge_r;

endmodule // wake_edge_detect

`default_nettype wire
